// >>> design/fdp_pkg.sv
// Shared constants of the data page command unit and its core-side end.
package fdp_pkg;
	// Register offsets on the special function register link.
	localparam logic [7:0] OFS_CMD   = 8'hb9;
	localparam logic [7:0] OFS_PAGE  = 8'hc6;
	localparam logic [7:0] OFS_DATA0 = 8'hbc;
	localparam logic [7:0] OFS_DATA1 = 8'hbd;
	localparam logic [7:0] OFS_DATA2 = 8'hbe;
	localparam logic [7:0] OFS_DATA3 = 8'hbf;
	// Core-side local registers, selected by address bit 8.
	localparam logic [8:0] OFS_STATUS = 9'h100;
	localparam logic [8:0] OFS_TIMER  = 9'h101;
	localparam int unsigned STAT_HOLD_BIT    = 0;
	localparam int unsigned STAT_REFUSED_BIT = 1;
	localparam int unsigned STAT_IRQ_BIT     = 2;
	// Command codes.
	localparam logic [7:0] CMD_READ       = 8'h01;
	localparam logic [7:0] CMD_PROGRAM    = 8'h02;
	localparam logic [7:0] CMD_INTERNAL   = 8'h03;
	localparam logic [7:0] CMD_VERIFY     = 8'h04;
	localparam logic [7:0] CMD_ERASE      = 8'h05;
	localparam logic [7:0] CMD_ERASE_ALL  = 8'h06;
	localparam logic [7:0] CMD_FIRST_FREE = 8'h07;
	localparam logic [7:0] VERIFY_PASS    = 8'h00;
	localparam logic [7:0] VERIFY_FAIL    = 8'hff;
	// Array geometry.
	localparam int unsigned PAGE_BYTES = 4;
	localparam int unsigned PAGES      = 160;
	localparam int unsigned MEM_BYTES  = 640;
	localparam logic [7:0]  LAST_PAGE  = 8'h9f;
	localparam logic [7:0]  ERASED     = 8'hff;
	// Reset values.
	localparam logic [7:0] RST_CMD  = 8'h00;
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	// Timing at the core clock rate.
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned ERASE_PAGE_MS  = 2;
	localparam int unsigned ERASE_ALL_MS   = 2;
	localparam int unsigned PROGRAM_US     = 250;
	localparam int unsigned ERASE_PAGE_CYC = ERASE_PAGE_MS * 1000 * CLK_MHZ;
	localparam int unsigned ERASE_ALL_CYC  = ERASE_ALL_MS * 1000 * CLK_MHZ;
	localparam int unsigned PROGRAM_CYC    = PROGRAM_US * CLK_MHZ;
	localparam int unsigned CNT_W          = 20;
endpackage : fdp_pkg

// >>> design/fdp_link_if.sv
// Register link between the core end and the data page command unit.
`timescale 1ns/1ps
interface fdp_link_if;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;
	logic       core_hold;

	modport dev (
		input  sfr_addr,
		input  sfr_wdata,
		input  sfr_wr,
		input  sfr_rd,
		output sfr_rdata,
		output core_hold
	);

	modport core (
		output sfr_addr,
		output sfr_wdata,
		output sfr_wr,
		output sfr_rd,
		input  sfr_rdata,
		input  core_hold
	);
endinterface : fdp_link_if

// >>> design/fdp_core_end.sv
// Core end: forwards software accesses and honours the stall.
`timescale 1ns/1ps
module fdp_core_end
	import fdp_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic       I_MCLK,
	input  wire logic       I_RST_B,
	input  wire logic       I_CE,
	// Link to the command unit.
	fdp_link_if.core        LINK,
	// Software port.
	input  wire logic [8:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output logic      [7:0] O_RDATA,
	// Interrupt request and status.
	input  wire logic       I_IRQ,
	output logic            O_IRQ_TAKEN,
	output logic            O_HELD
);
	logic       is_local;
	logic       bad_cmd;
	logic       fwd_ok;
	logic       take;
	logic       refused_r;
	logic       refused_nxt;
	logic       pend_r;
	logic       pend_nxt;
	logic       taken_r;
	logic       taken_nxt;
	logic [7:0] timer_r;
	logic [7:0] timer_nxt;
	logic [7:0] lrdata_r;
	logic [7:0] lrdata_nxt;
	logic       sel_local_r;
	logic       sel_local_nxt;

	// Forwarding, filtering and local registers.
	always_comb begin
		is_local = I_ADDR[8];
		bad_cmd = (I_ADDR[7:0] == OFS_CMD) &&
			((I_WDATA == CMD_INTERNAL) || (I_WDATA >= CMD_FIRST_FREE));
		fwd_ok = !is_local && !LINK.core_hold && !(I_WR && bad_cmd);
		LINK.sfr_addr = I_ADDR[7:0];
		LINK.sfr_wdata = I_WDATA;
		LINK.sfr_wr = I_WR && fwd_ok;
		LINK.sfr_rd = I_RD && fwd_ok;
		refused_nxt = (!is_local && (I_WR || I_RD) && !fwd_ok) ||
			(refused_r && !(I_WR && (I_ADDR == OFS_STATUS) &&
			I_WDATA[STAT_REFUSED_BIT]));
		timer_nxt = timer_r + 8'h01;
		take = pend_r && !LINK.core_hold;
		pend_nxt = I_IRQ || (pend_r && !take);
		taken_nxt = take;
		sel_local_nxt = I_RD && is_local;
		lrdata_nxt = 8'h00;
		if (I_RD && (I_ADDR == OFS_STATUS)) begin
			lrdata_nxt[STAT_HOLD_BIT] = LINK.core_hold;
			lrdata_nxt[STAT_REFUSED_BIT] = refused_r;
			lrdata_nxt[STAT_IRQ_BIT] = pend_r;
		end else if (I_RD && (I_ADDR == OFS_TIMER)) begin
			lrdata_nxt = timer_r;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			refused_r <= 1'b0;
			pend_r <= 1'b0;
			taken_r <= 1'b0;
			timer_r <= 8'h00;
			lrdata_r <= 8'h00;
			sel_local_r <= 1'b0;
		end else if (I_CE) begin
			refused_r <= refused_nxt;
			pend_r <= pend_nxt;
			taken_r <= taken_nxt;
			timer_r <= timer_nxt;
			lrdata_r <= lrdata_nxt;
			sel_local_r <= sel_local_nxt;
		end
	end

	assign O_RDATA = sel_local_r ? lrdata_r : LINK.sfr_rdata;
	assign O_IRQ_TAKEN = taken_r;
	assign O_HELD = LINK.core_hold;
endmodule : fdp_core_end

// >>> design/fdp_dev_end.sv
// Data page command unit: registers, command interpreter and array.
// Operation
// - Code 01H copies page into data registers.
// - Code 02H programs data registers into page.
// - Software never writes 03H or 07H-FFH.
// - Code 04H compares; command reads zero on match.
// - Code 05H erases the addressed page only.
// - Code 06H erases all 160 pages.
// - Erase about 2 ms, program 250 us.
// - Page read completes within one cycle.
// - Command write starts the operation at once.
// - Core held idle until operation finishes.
// - No interrupts taken while held; timers run.
// - Only erased FFH bytes accept programming.
// - Erase clears whole four-byte pages.
// - Software loads address, data, then command.
// - Byte update is read, modify, erase, program.
// - Software erases whole array during setup.
// - Valid page addresses are 00H to 9FH.
// - Eight-bit address, command and four data registers.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module fdp_dev_end
	import fdp_pkg::*;
#(
	parameter int unsigned PROG_CYCLES      = PROGRAM_CYC,
	parameter int unsigned ERASE_CYCLES     = ERASE_PAGE_CYC,
	parameter int unsigned ERASE_ALL_CYCLES = ERASE_ALL_CYC
)
(
	// Clock, reset and enable.
	input  wire logic I_MCLK,
	input  wire logic I_RST_B,
	input  wire logic I_CE,
	// Register link from the core end.
	fdp_link_if.dev   LINK,
	// Status towards the rest of the chip.
	output logic      O_BUSY,
	output logic      O_DONE
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_PROG  = 2'b01,
		ST_ERASE = 2'b11,
		ST_ERALL = 2'b10
	} fdp_state_t;

	typedef enum logic [1:0] {
		MOP_NONE  = 2'b00,
		MOP_PROG  = 2'b01,
		MOP_ERASE = 2'b10,
		MOP_ERALL = 2'b11
	} fdp_mop_t;

	generate
		if ((PROG_CYCLES < 1) || (PROG_CYCLES >= (1 << CNT_W)) ||
			(ERASE_CYCLES < 1) || (ERASE_CYCLES >= (1 << CNT_W)) ||
			(ERASE_ALL_CYCLES < 1) ||
			(ERASE_ALL_CYCLES >= (1 << CNT_W))) begin : g_bad_cycles
			$error("Operation cycle count outside counter range.");
		end
	endgenerate

	fdp_state_t       state_r;
	fdp_state_t       state_nxt;
	fdp_mop_t         mop;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [7:0]       cmd_r;
	logic [7:0]       cmd_nxt;
	logic [7:0]       page_r;
	logic [7:0]       page_nxt;
	logic [7:0]       data_r [PAGE_BYTES];
	logic [7:0]       data_nxt [PAGE_BYTES];
	logic [7:0]       rdata_r;
	logic [7:0]       rdata_nxt;
	logic             done_r;
	logic             done_nxt;
	logic             page_ok;
	logic             match;
	logic             cmd_wr;
	logic [9:0]       base;
	logic [7:0]       page_bytes [PAGE_BYTES];
	logic [7:0]       mem [MEM_BYTES];

	// Current page contents, one byte per lane.
	genvar g;
	generate
		for (g = 0; g < PAGE_BYTES; g++) begin : g_lane
			assign page_bytes[g] = mem[base + 10'(g)];
		end
	endgenerate

	// Command interpreter and register file.
	always_comb begin
		base = {page_r, 2'b00};
		page_ok = (page_r <= LAST_PAGE);
		match = page_ok;
		for (int i = 0; i < PAGE_BYTES; i++) begin
			if (page_bytes[i] != data_r[i]) begin
				match = 1'b0;
			end
		end
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		cmd_nxt = cmd_r;
		page_nxt = page_r;
		data_nxt = data_r;
		done_nxt = 1'b0;
		mop = MOP_NONE;
		cmd_wr = 1'b0;
		if (state_r == ST_IDLE) begin
			if (LINK.sfr_wr) begin
				if (LINK.sfr_addr == OFS_CMD) begin
					cmd_wr = 1'b1;
				end else if (LINK.sfr_addr == OFS_PAGE) begin
					page_nxt = LINK.sfr_wdata;
				end else if (LINK.sfr_addr == OFS_DATA0) begin
					data_nxt[0] = LINK.sfr_wdata;
				end else if (LINK.sfr_addr == OFS_DATA1) begin
					data_nxt[1] = LINK.sfr_wdata;
				end else if (LINK.sfr_addr == OFS_DATA2) begin
					data_nxt[2] = LINK.sfr_wdata;
				end else if (LINK.sfr_addr == OFS_DATA3) begin
					data_nxt[3] = LINK.sfr_wdata;
				end
			end
			if (cmd_wr) begin
				cmd_nxt = LINK.sfr_wdata;
				case (LINK.sfr_wdata)
					CMD_READ: begin
						if (page_ok) begin
							data_nxt = page_bytes;
						end
						done_nxt = 1'b1;
					end
					CMD_PROGRAM: begin
						if (page_ok) begin
							state_nxt = ST_PROG;
							cnt_nxt = CNT_W'(PROG_CYCLES - 1);
						end
					end
					CMD_VERIFY: begin
						cmd_nxt = match ? VERIFY_PASS : VERIFY_FAIL;
						done_nxt = 1'b1;
					end
					CMD_ERASE: begin
						if (page_ok) begin
							state_nxt = ST_ERASE;
							cnt_nxt = CNT_W'(ERASE_CYCLES - 1);
						end
					end
					CMD_ERASE_ALL: begin
						state_nxt = ST_ERALL;
						cnt_nxt = CNT_W'(ERASE_ALL_CYCLES - 1);
					end
					default: begin
						done_nxt = 1'b0;
					end
				endcase
			end
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - CNT_W'(1);
		end else begin
			state_nxt = ST_IDLE;
			done_nxt = 1'b1;
			case (state_r)
				ST_PROG:  mop = MOP_PROG;
				ST_ERASE: mop = MOP_ERASE;
				default:  mop = MOP_ERALL;
			endcase
		end
		rdata_nxt = 8'h00;
		if (LINK.sfr_rd) begin
			if (LINK.sfr_addr == OFS_CMD) begin
				rdata_nxt = cmd_r;
			end else if (LINK.sfr_addr == OFS_PAGE) begin
				rdata_nxt = page_r;
			end else if (LINK.sfr_addr == OFS_DATA0) begin
				rdata_nxt = data_r[0];
			end else if (LINK.sfr_addr == OFS_DATA1) begin
				rdata_nxt = data_r[1];
			end else if (LINK.sfr_addr == OFS_DATA2) begin
				rdata_nxt = data_r[2];
			end else if (LINK.sfr_addr == OFS_DATA3) begin
				rdata_nxt = data_r[3];
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			cmd_r <= RST_CMD;
			page_r <= RST_PAGE;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				data_r[i] <= RST_DATA;
			end
			rdata_r <= 8'h00;
			done_r <= 1'b0;
		end else if (I_CE) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			cmd_r <= cmd_nxt;
			page_r <= page_nxt;
			data_r <= data_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
		end
	end

	// The array keeps its contents across reset.
	always_ff @(posedge I_MCLK) begin
		if (I_CE) begin
			case (mop)
				MOP_PROG: begin
					for (int i = 0; i < PAGE_BYTES; i++) begin
						if (page_bytes[i] == ERASED) begin
							mem[base + 10'(i)] <= data_r[i];
						end
					end
				end
				MOP_ERASE: begin
					for (int i = 0; i < PAGE_BYTES; i++) begin
						mem[base + 10'(i)] <= ERASED;
					end
				end
				MOP_ERALL: begin
					for (int k = 0; k < MEM_BYTES; k++) begin
						mem[k] <= ERASED;
					end
				end
				default: begin
				end
			endcase
		end
	end

	assign LINK.sfr_rdata = rdata_r;
	assign LINK.core_hold = (state_r != ST_IDLE);
	assign O_BUSY = (state_r != ST_IDLE);
	assign O_DONE = done_r;
endmodule : fdp_dev_end

// >>> dv/fdp_link_checker.sv
// Assertions on the link between the core end and the command unit.
`timescale 1ns/1ps
module fdp_link_checker
	import fdp_pkg::*;
#(
	parameter int unsigned PROG_CYCLES      = 8,
	parameter int unsigned ERASE_CYCLES     = 12,
	parameter int unsigned ERASE_ALL_CYCLES = 16
)
(
	input wire logic       I_MCLK,
	input wire logic       I_RST_B,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       core_hold
);
	logic [7:0]  page_r;
	logic [7:0]  op_r;
	logic [19:0] cnt_r;
	logic [19:0] exp_len;
	logic        ok;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	// Track the page and command last taken, and the length of a hold.
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			page_r <= 8'h00;
			op_r   <= 8'h00;
			cnt_r  <= 20'h0;
		end else begin
			if (sfr_wr && !core_hold && sfr_addr == OFS_PAGE)
				page_r <= sfr_wdata;
			if (sfr_wr && !core_hold && sfr_addr == OFS_CMD)
				op_r <= sfr_wdata;
			cnt_r <= core_hold ? cnt_r + 20'h1 : 20'h0;
		end
	end
	assign ok = page_r <= LAST_PAGE;
	assign exp_len = 20'(op_r == CMD_PROGRAM ? PROG_CYCLES :
		op_r == CMD_ERASE ? ERASE_CYCLES : ERASE_ALL_CYCLES);
	sequence s_cmd(logic [7:0] c);
		sfr_wr && !core_hold && sfr_addr == OFS_CMD && sfr_wdata == c;
	endsequence
	a_prog_starts: assert property (s_cmd(CMD_PROGRAM) ##0 ok |=> core_hold)
		else $error("program did not hold the core");
	a_erase_starts: assert property (s_cmd(CMD_ERASE) ##0 ok |=> core_hold)
		else $error("page erase did not start at once");
	a_all_holds: assert property (s_cmd(CMD_ERASE_ALL) |=> core_hold [*8])
		else $error("erase all released the core early");
	a_hold_length: assert property ($fell(core_hold) |-> cnt_r == exp_len)
		else $error("hold length wrong");
	a_read_quick: assert property (s_cmd(CMD_READ) |=> !core_hold)
		else $error("page read held the core");
	a_verify_quick: assert property (s_cmd(CMD_VERIFY) |=> !core_hold)
		else $error("verify held the core");
	a_bad_page: assert property (sfr_wr && !core_hold && sfr_addr == OFS_CMD
		&& (sfr_wdata == CMD_PROGRAM || sfr_wdata == CMD_ERASE) && !ok
		|=> !core_hold [*2]) else $error("bad page command ran");
	a_held_quiet: assert property (core_hold |-> !sfr_wr && !sfr_rd)
		else $error("access passed while core held");
endmodule : fdp_link_checker

// >>> dv/flash_data_page_command_unit_bench.sv
// Self-checking bench for the command unit and its core end.
`timescale 1ns/1ps
module flash_data_page_command_unit_bench;
	import fdp_pkg::*;
	localparam int unsigned PC = 8;
	localparam int unsigned EC = 12;
	localparam int unsigned AC = 16;
	localparam logic [8:0] A_CMD = {1'b0, OFS_CMD};
	localparam logic [8:0] A_PG  = {1'b0, OFS_PAGE};
	localparam logic [8:0] A_D0  = {1'b0, OFS_DATA0};
	logic        clk, rst_b, wr, rd, rd_d, irq, irq_taken, held, busy, done;
	logic [8:0]  addr;
	logic [7:0]  wdata, rdata, p;
	logic [31:0] d;
	logic [7:0]  exp_q[$];
	int          n_errors, checked, n_irq, tick;
	logic [7:0]  rsv [3] = '{8'h03, 8'h07, 8'hff};
	fdp_link_if i_fdp_link_if ();
	fdp_core_end i_fdp_core_end (.I_MCLK(clk), .I_RST_B(rst_b),
		.I_CE(1'b1), .LINK(i_fdp_link_if), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_IRQ(irq),
		.O_IRQ_TAKEN(irq_taken), .O_HELD(held));
	fdp_dev_end #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC),
		.ERASE_ALL_CYCLES(AC)) i_fdp_dev_end (.I_MCLK(clk),
		.I_RST_B(rst_b), .I_CE(1'b1), .LINK(i_fdp_link_if),
		.O_BUSY(busy), .O_DONE(done));
	fdp_link_checker #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC),
		.ERASE_ALL_CYCLES(AC)) i_fdp_link_checker (.I_MCLK(clk),
		.I_RST_B(rst_b), .sfr_addr(i_fdp_link_if.sfr_addr),
		.sfr_wdata(i_fdp_link_if.sfr_wdata), .sfr_wr(i_fdp_link_if.sfr_wr),
		.sfr_rd(i_fdp_link_if.sfr_rd), .sfr_rdata(i_fdp_link_if.sfr_rdata),
		.core_hold(i_fdp_link_if.core_hold));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			$display("[ERR] %0t got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask : chk
	task wrap_up();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task put(input logic [8:0] a, input logic [7:0] v);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : put
	task get(input logic [8:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask : get
	task hold_wait();
		int i;
		i = 0;
		while (held !== 1'b0 && i < 100) begin
			@(posedge clk);
			i++;
		end
		if (held !== 1'b0) begin
			$display("[ERR] %0t got %h exp %h", $time, held, 1'b0);
			n_errors++;
		end
	endtask : hold_wait
	task cmd(input logic [7:0] c, input logic e = 1'b1);
		logic b;
		b = e && (c == CMD_PROGRAM || c == CMD_ERASE ||
			c == CMD_ERASE_ALL);
		put(A_CMD, c);
		chk(8'(busy), 8'(b));
		hold_wait();
		chk(8'(done), 8'(e));
	endtask : cmd
	task ld(input logic [7:0] pg, input logic [31:0] v);
		put(A_PG, pg);
		for (int k = 0; k < 4; k++)
			put(A_D0 + 9'(k), v[8*k+:8]);
	endtask : ld
	task chkpg(input logic [7:0] pg, input logic [31:0] e);
		put(A_PG, pg);
		cmd(CMD_READ);
		for (int k = 0; k < 4; k++)
			get(A_D0 + 9'(k), e[8*k+:8]);
	endtask : chkpg
	// Result of programming zeros over a page: only erased bytes change.
	function automatic logic [31:0] over(input logic [31:0] o);
		for (int k = 0; k < 4; k++)
			over[8*k+:8] = o[8*k+:8] == ERASED ? 8'h00 : o[8*k+:8];
	endfunction : over
	// Compare each read result with the oldest expectation.
	always @(posedge clk) begin
		if (rd_d === 1'b1)
			chk(rdata, exp_q.pop_front());
		if (irq_taken === 1'b1 && held !== 1'b0) begin
			$display("[ERR] %0t got %h exp %h", $time, held, 1'b0);
			n_errors++;
		end
		if (irq_taken === 1'b1)
			n_irq++;
		if (rst_b === 1'b1)
			tick <= tick + 1;
		rd_d <= rd;
	end
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
	initial begin
		{rst_b, wr, rd, irq, addr, wdata} = '0;
		n_errors = 0;
		checked = 0;
		n_irq = 0;
		d = $urandom(32'h8305);
		p = 8'(2 * ($urandom % 80));
		d = $urandom;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		cmd(CMD_ERASE_ALL);
		chkpg(p, 32'hffffffff);
		$display("erase all test done");
		ld(p, d);
		cmd(CMD_PROGRAM);
		ld(p ^ 8'h01, ~d);
		cmd(CMD_PROGRAM);
		chkpg(p, d);
		ld(p, d);
		cmd(CMD_VERIFY);
		get(A_CMD, VERIFY_PASS);
		ld(p, d ^ 32'h1);
		cmd(CMD_VERIFY);
		get(A_CMD, VERIFY_FAIL);
		ld(p, 32'h0);
		cmd(CMD_PROGRAM);
		chkpg(p, over(d));
		$display("program and verify test done");
		cmd(CMD_ERASE);
		chkpg(p, 32'hffffffff);
		chkpg(p ^ 8'h01, ~d);
		$display("page erase test done");
		put(A_PG, p ^ 8'h01);
		cmd(CMD_READ);
		put(A_D0 + 9'h001, 8'hf3);
		cmd(CMD_ERASE);
		cmd(CMD_PROGRAM);
		chkpg(p ^ 8'h01, {~d[31:16], 8'hf3, ~d[7:0]});
		$display("byte update test done");
		ld(8'ha0, d);
		cmd(CMD_ERASE, 1'b0);
		cmd(CMD_PROGRAM, 1'b0);
		cmd(CMD_VERIFY);
		get(A_CMD, VERIFY_FAIL);
		foreach (rsv[i]) begin
			put(A_CMD, rsv[i]);
			get(OFS_STATUS, 8'(1 << STAT_REFUSED_BIT));
			put(OFS_STATUS, 8'(1 << STAT_REFUSED_BIT));
		end
		get(A_CMD, VERIFY_FAIL);
		$display("bad page and reserved code test done");
		put(A_PG, p);
		put(A_CMD, CMD_ERASE);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		hold_wait();
		get(OFS_TIMER, 8'(tick + 1));
		repeat (4) @(posedge clk);
		chk(8'(n_irq), 8'h01);
		$display("interrupt test done");
		wrap_up();
	end
endmodule : flash_data_page_command_unit_bench
